// ===== tmps_top.sv
`timescale 1ns/1ps
// Operation
// - Eight trunks, up to ten ports each
// - Unicast hash: SA+DA default, SA, DA, port (port only with CTRL_RING set, else SA+DA)
// - Multicast uses the same hash options
// - Trunk destination entry yields its group number
// - Drop unicast when source in destination trunk
// - Eight select slots per trunk, hash picks one
// - Multicast excludes source port and its trunk
// - Multicast keeps one hashed member per trunk
// - Down member traffic moves to live members
// - Address, flow and port mirroring offered
// - Mirror flag plus per-address source/destination select
// - Matching source or destination copied to monitor
// - Programmed address pair copied when enabled
// - Optional reverse direction flow copy
// - Port mirror low-speed ports, ingress or egress
// - Two monitor ports configurable at once
// - Monitor ports carry no regular traffic
module tmps_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Lookup result from the address lookup engine
    input  wire logic        req_valid,
    input  wire logic        req_mcast,
    input  wire logic [3:0]  req_src_port,
    input  wire logic [47:0] req_sa,
    input  wire logic [47:0] req_da,
    input  wire logic [3:0]  req_dst_port,
    input  wire logic        req_dst_trunk_member,
    input  wire logic [2:0]  req_dst_trunk,
    input  wire logic [9:0]  req_vlan_mask,
    input  wire logic        sa_entry_mirror,
    input  wire logic        sa_entry_match_dst,
    input  wire logic        da_entry_mirror,
    input  wire logic        da_entry_match_dst,
    // Port link state from the MACs
    input  wire logic [9:0]  link_up,
    // Forwarding decision
    output logic             res_valid,
    output logic             res_mcast,
    output logic             res_discard,
    output logic [9:0]       res_fwd,
    output logic [9:0]       res_mirror
);
    tmps_reg_if  rif ();
    tmps_hash_if hif ();

    logic [8:0]  ctrl;
    logic [15:0] mon;
    logic [47:0] fsa;
    logic [47:0] fda;
    logic [15:0] disc_cnt;
    logic [9:0]  tmem [tmps_pkg::NTRK];
    logic [3:0]  tsel [tmps_pkg::NTRK * tmps_pkg::NSEL];
    logic [3:0]  msrc [tmps_pkg::NMON];
    logic [3:0]  mdst [tmps_pkg::NMON];
    logic [1:0]  men;
    logic [1:0]  megr;
    logic [9:0]  mon_mask;
    logic [9:0]  pm_mask [tmps_pkg::NMON];
    logic [5:0]  tsel_i;
    logic        tsel_hit;

    function automatic logic [9:0] port_oh(input logic [3:0] p);
        return (p < 4'hA) ? (10'h001 << p) : 10'h000;
    endfunction : port_oh

    function automatic logic [9:0] lowest(input logic [9:0] m);
        return m & (~m + 10'h001);
    endfunction : lowest

    tmps_ahb_slv u_slv (
        .clk       (clk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .r         (rif.slv)
    );

    tmps_hash u_hash (
        .h (hif.hash)
    );

    assign hif.sa   = req_sa;
    assign hif.da   = req_da;
    assign hif.src  = req_src_port;
    assign hif.mode = tmps_pkg::tmps_hash_e'(ctrl[tmps_pkg::CTRL_HASH +: 2]);
    assign hif.ring = ctrl[tmps_pkg::CTRL_RING];

    assign tsel_hit = rif.addr >= tmps_pkg::OFS_TSEL && rif.addr < tmps_pkg::OFS_TSEL_E;
    assign tsel_i   = 6'((rif.addr - tmps_pkg::OFS_TSEL) >> 2);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= tmps_pkg::CTRL_RST;
            mon  <= tmps_pkg::MON_RST;
        end else if (rif.wr && rif.addr == tmps_pkg::OFS_CTRL) begin
            ctrl <= rif.wdata[8:0];
        end else if (rif.wr && rif.addr == tmps_pkg::OFS_MON) begin
            mon <= rif.wdata[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fsa <= tmps_pkg::FLOW_RST;
            fda <= tmps_pkg::FLOW_RST;
        end else if (rif.wr) begin
            case (rif.addr)
                tmps_pkg::OFS_FSA_LO: fsa[31:0]  <= rif.wdata;
                tmps_pkg::OFS_FSA_HI: fsa[47:32] <= rif.wdata[15:0];
                tmps_pkg::OFS_FDA_LO: fda[31:0]  <= rif.wdata;
                tmps_pkg::OFS_FDA_HI: fda[47:32] <= rif.wdata[15:0];
                default: ;
            endcase
        end
    end

    // Trunk membership and member-select slots
    genvar g;
    generate
        for (g = 0; g < tmps_pkg::NTRK; g++) begin : g_tmem
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tmem[g] <= tmps_pkg::TMEM_RST;
                end else if (rif.wr && rif.addr == tmps_pkg::OFS_TMEM + 12'(4 * g)) begin
                    tmem[g] <= rif.wdata[9:0];
                end
            end
        end
        for (g = 0; g < tmps_pkg::NTRK * tmps_pkg::NSEL; g++) begin : g_tsel
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    tsel[g] <= tmps_pkg::TSEL_RST;
                end else if (rif.wr && tsel_hit && tsel_i == 6'(g)) begin
                    tsel[g] <= rif.wdata[3:0];
                end
            end
        end
        for (g = 0; g < tmps_pkg::NMON; g++) begin : g_mon
            assign msrc[g] = mon[tmps_pkg::MON_STEP * g + tmps_pkg::MON_SRC +: 4];
            assign mdst[g] = mon[tmps_pkg::MON_STEP * g + tmps_pkg::MON_DST +: 4];
            assign men[g]  = ctrl[tmps_pkg::CTRL_MEN + 2 * g];
            assign megr[g] = ctrl[tmps_pkg::CTRL_MEGR - 2 + 2 * g + 1];
        end
    endgenerate

    always_comb begin
        rif.rdata = 32'h00000000;
        case (rif.addr)
            tmps_pkg::OFS_CTRL:   rif.rdata = {23'h000000, ctrl};
            tmps_pkg::OFS_MON:    rif.rdata = {16'h0000, mon};
            tmps_pkg::OFS_FSA_LO: rif.rdata = fsa[31:0];
            tmps_pkg::OFS_FSA_HI: rif.rdata = {16'h0000, fsa[47:32]};
            tmps_pkg::OFS_FDA_LO: rif.rdata = fda[31:0];
            tmps_pkg::OFS_FDA_HI: rif.rdata = {16'h0000, fda[47:32]};
            tmps_pkg::OFS_STAT:   rif.rdata = {16'h0000, disc_cnt};
            tmps_pkg::OFS_LINK:   rif.rdata = {22'h000000, link_up};
            default: begin
                if (tsel_hit) begin
                    rif.rdata = {28'h0000000, tsel[tsel_i]};
                end else if (rif.addr[11:5] == tmps_pkg::OFS_TMEM[11:5] && rif.addr[1:0] == 2'b00) begin
                    rif.rdata = {22'h000000, tmem[rif.addr[4:2]]};
                end
            end
        endcase
    end

    // Forwarding decision
    logic [9:0] src_oh;
    logic [9:0] src_grp;
    logic [9:0] trk_all;
    logic [9:0] dst_grp;
    logic [9:0] uc_oh;
    logic [9:0] uc_fwd;
    logic [9:0] mc_cand;
    logic [9:0] mc_fwd;
    logic [9:0] fwd;
    logic       uc_drop;
    logic       addr_mir;
    logic       flow_mir;

    always_comb begin
        logic [9:0] live;
        logic [9:0] pick;
        live     = 10'h000;
        pick     = 10'h000;
        src_oh   = port_oh(req_src_port);
        src_grp  = src_oh;
        trk_all  = 10'h000;
        mon_mask = 10'h000;
        for (int k = 0; k < tmps_pkg::NMON; k++) begin
            if (men[k] && mdst[k] < 4'(tmps_pkg::NLOW)) begin
                mon_mask = mon_mask | port_oh(mdst[k]);
            end
        end
        for (int t = 0; t < tmps_pkg::NTRK; t++) begin
            trk_all = trk_all | tmem[t];
            if (req_src_port < 4'hA && tmem[t][req_src_port]) begin
                src_grp = src_grp | tmem[t];
            end
        end
        dst_grp = tmem[req_dst_trunk];
        uc_drop = req_dst_trunk_member && req_src_port < 4'hA
                  && dst_grp[req_src_port];
        if (req_dst_trunk_member) begin
            pick = port_oh(tsel[{req_dst_trunk, hif.idx}]);
            live = dst_grp & link_up;
            uc_oh = ((pick & live) != 10'h000) ? pick : lowest(live);
        end else begin
            uc_oh = port_oh(req_dst_port);
        end
        uc_fwd  = uc_drop ? 10'h000 : (uc_oh & ~mon_mask);
        mc_cand = req_vlan_mask & ~src_grp & ~mon_mask;
        mc_fwd  = mc_cand & ~trk_all;
        for (int t = 0; t < tmps_pkg::NTRK; t++) begin
            live = mc_cand & tmem[t] & link_up;
            pick = port_oh(tsel[t * tmps_pkg::NSEL + int'(hif.idx)]);
            mc_fwd = mc_fwd | (((pick & live) != 10'h000) ? pick : lowest(live));
        end
        fwd = req_mcast ? mc_fwd : uc_fwd;
    end

    // Mirror copies
    always_comb begin
        addr_mir = (sa_entry_mirror && !sa_entry_match_dst)
                   || (da_entry_mirror && da_entry_match_dst);
        flow_mir = ctrl[tmps_pkg::CTRL_FLOW]
                   && ((req_sa == fsa && req_da == fda)
                   || (ctrl[tmps_pkg::CTRL_FREV] && req_sa == fda && req_da == fsa));
        for (int k = 0; k < tmps_pkg::NMON; k++) begin
            pm_mask[k] = 10'h000;
            if (men[k] && msrc[k] < 4'(tmps_pkg::NLOW) && mdst[k] < 4'(tmps_pkg::NLOW)
                && (megr[k] ? fwd[msrc[k]] : req_src_port == msrc[k])) begin
                pm_mask[k] = port_oh(mdst[k]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_valid   <= 1'b0;
            res_mcast   <= 1'b0;
            res_discard <= 1'b0;
            res_fwd     <= 10'h000;
            res_mirror  <= 10'h000;
        end else begin
            res_valid   <= req_valid;
            res_mcast   <= req_valid && req_mcast;
            res_discard <= req_valid && !req_mcast && uc_drop;
            res_fwd     <= req_valid ? fwd : 10'h000;
            res_mirror  <= req_valid ? (((addr_mir || flow_mir) ? mon_mask : 10'h000)
                                        | pm_mask[0] | pm_mask[1]) : 10'h000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            disc_cnt <= tmps_pkg::CNT_RST;
        end else if (req_valid && !req_mcast && uc_drop) begin
            disc_cnt <= disc_cnt + 16'h0001;
        end
    end

    // Checks
    logic mc_ok;
    always_comb begin
        mc_ok = 1'b1;
        for (int t = 0; t < tmps_pkg::NTRK; t++) begin
            if (!$onehot0(res_fwd & tmem[t])) begin
                mc_ok = 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    uc_discard_a: assert property (req_valid && !req_mcast && uc_drop
        |=> res_discard && res_fwd == 10'h000) else $error("trunk-local unicast not dropped");
    uc_trunk_a: assert property (req_valid && !req_mcast && req_dst_trunk_member
        && !uc_drop |=> $onehot0(res_fwd) && (res_fwd & ~$past(dst_grp)) == 10'h000)
        else $error("unicast left its trunk");
    uc_fail_a: assert property (req_valid && !req_mcast && req_dst_trunk_member
        && !uc_drop && (dst_grp & link_up & ~mon_mask) != 10'h000
        |=> (res_fwd & ~$past(link_up)) == 10'h000) else $error("sent to down member");
    mc_src_a: assert property (req_valid && req_mcast
        |=> (res_fwd & $past(src_grp)) == 10'h000) else $error("multicast back to source group");
    mc_one_a: assert property (res_valid && res_mcast |-> mc_ok)
        else $error("multicast hit two members of a trunk");
    mon_excl_a: assert property (req_valid |=> (res_fwd & $past(mon_mask)) == 10'h000)
        else $error("regular traffic on monitor port");
    addr_mir_a: assert property (req_valid && sa_entry_mirror && !sa_entry_match_dst
        |=> (res_mirror & $past(mon_mask)) == $past(mon_mask)) else $error("address copy missing");
    flow_mir_a: assert property (req_valid && ctrl[tmps_pkg::CTRL_FLOW]
        && req_sa == fsa && req_da == fda ##1 res_valid |-> (res_mirror & $past(mon_mask))
        == $past(mon_mask)) else $error("flow copy missing");
    flow_rev_a: assert property (req_valid && !ctrl[tmps_pkg::CTRL_FREV] && !addr_mir
        && fsa != fda && req_sa == fda && req_da == fsa
        |=> (res_mirror & ~$past(pm_mask[0] | pm_mask[1])) == 10'h000)
        else $error("reverse flow copied while off");
    port_ing_a: assert property (req_valid && men[0] && !megr[0] && req_src_port == msrc[0]
        && msrc[0] < 4'h8 && mdst[0] < 4'h8 |=> res_mirror[$past(mdst[0])])
        else $error("ingress port copy missing");

    mc_trunk_c: cover property (req_valid && req_mcast && trk_all != 10'h000 ##1 res_fwd != 10'h000);
    flow_rev_c: cover property (req_valid && flow_mir && req_sa == fda);
    port_egr_c: cover property (req_valid && megr[1] ##1 res_mirror != 10'h000);
endmodule : tmps_top

// ===== tmps_pkg.sv
package tmps_pkg;
    localparam int NPORT = 10;
    localparam int NLOW  = 8;
    localparam int NTRK  = 8;
    localparam int NSEL  = 8;
    localparam int NMON  = 2;

    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_MON    = 12'h004;
    localparam logic [11:0] OFS_FSA_LO = 12'h008;
    localparam logic [11:0] OFS_FSA_HI = 12'h00C;
    localparam logic [11:0] OFS_FDA_LO = 12'h010;
    localparam logic [11:0] OFS_FDA_HI = 12'h014;
    localparam logic [11:0] OFS_STAT   = 12'h018;
    localparam logic [11:0] OFS_LINK   = 12'h01C;
    localparam logic [11:0] OFS_TMEM   = 12'h020;
    localparam logic [11:0] OFS_TSEL   = 12'h040;
    localparam logic [11:0] OFS_TSEL_E = 12'h140;

    localparam int CTRL_HASH = 0;
    localparam int CTRL_RING = 2;
    localparam int CTRL_FLOW = 3;
    localparam int CTRL_FREV = 4;
    localparam int CTRL_MEN  = 5;
    localparam int CTRL_MEGR = 7;
    localparam int MON_SRC   = 0;
    localparam int MON_DST   = 4;
    localparam int MON_STEP  = 8;

    localparam logic [8:0]  CTRL_RST = 9'h000;
    localparam logic [15:0] MON_RST  = 16'h0000;
    localparam logic [47:0] FLOW_RST = 48'h000000000000;
    localparam logic [9:0]  TMEM_RST = 10'h000;
    localparam logic [3:0]  TSEL_RST = 4'h0;
    localparam logic [15:0] CNT_RST  = 16'h0000;

    typedef enum logic [1:0] {
        HASH_SADA = 2'b00,
        HASH_SA   = 2'b01,
        HASH_DA   = 2'b10,
        HASH_PORT = 2'b11
    } tmps_hash_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WR   = 2'b01,
        BUS_RDW  = 2'b10,
        BUS_RDD  = 2'b11
    } tmps_bus_e;
endpackage : tmps_pkg

// ===== tmps_if.sv
`timescale 1ns/1ps
interface tmps_reg_if;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slv  (output wr, addr, wdata, input rdata);
    modport regs (input wr, addr, wdata, output rdata);
endinterface : tmps_reg_if

interface tmps_hash_if;
    logic [47:0]         sa;
    logic [47:0]         da;
    logic [3:0]          src;
    tmps_pkg::tmps_hash_e mode;
    logic                ring;
    logic [2:0]          idx;
    modport user (output sa, da, src, mode, ring, input idx);
    modport hash (input sa, da, src, mode, ring, output idx);
endinterface : tmps_hash_if

// ===== tmps_hash.sv
`timescale 1ns/1ps
module tmps_hash (
    tmps_hash_if.hash h
);
    function automatic logic [2:0] fold48(input logic [47:0] x);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 16; i++) begin
            r = r ^ x[i*3 +: 3];
        end
        return r;
    endfunction : fold48

    // Three-bit member index from the selected key fields
    always_comb begin
        case (h.mode)
            tmps_pkg::HASH_SA:   h.idx = fold48(h.sa);
            tmps_pkg::HASH_DA:   h.idx = fold48(h.da);
            tmps_pkg::HASH_PORT: h.idx = h.ring ? (h.src[2:0] ^ {2'b00, h.src[3]})
                                                : fold48(h.sa ^ h.da);
            default:             h.idx = fold48(h.sa ^ h.da);
        endcase
    end
endmodule : tmps_hash

// ===== tmps_ahb_slv.sv
`timescale 1ns/1ps
module tmps_ahb_slv (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Register side
    tmps_reg_if.slv          r
);
    tmps_pkg::tmps_bus_e state;
    tmps_pkg::tmps_bus_e next_state;
    logic [11:0]         addr_q;
    logic                take;

    // Only whole-word transfers are used; size is not checked
    assign take      = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);
    assign hreadyout = (state != tmps_pkg::BUS_RDW);
    assign hresp     = 1'b0;
    assign r.wr      = (state == tmps_pkg::BUS_WR);
    assign r.addr    = addr_q;
    assign r.wdata   = hwdata;

    always_comb begin
        case (state)
            tmps_pkg::BUS_RDW: next_state = tmps_pkg::BUS_RDD;
            tmps_pkg::BUS_IDLE,
            tmps_pkg::BUS_WR,
            tmps_pkg::BUS_RDD: begin
                if (take) begin
                    next_state = hwrite ? tmps_pkg::BUS_WR : tmps_pkg::BUS_RDW;
                end else begin
                    next_state = tmps_pkg::BUS_IDLE;
                end
            end
            default: next_state = tmps_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= tmps_pkg::BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 12'h000;
        end else if (take) begin
            addr_q <= haddr[11:0];
        end
    end

    // Read data sampled in the wait cycle, after any prior write landed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (state == tmps_pkg::BUS_RDW) begin
            hrdata <= r.rdata;
        end
    end
endmodule : tmps_ahb_slv

// ===== tmps_lookup_model.sv
`timescale 1ns/1ps
module tmps_lookup_model (
    // Clock
    input  wire logic   clk,
    // Lookup result
    output logic        req_valid,
    output logic        req_mcast,
    output logic [3:0]  req_src_port,
    output logic [47:0] req_sa,
    output logic [47:0] req_da,
    output logic [3:0]  req_dst_port,
    output logic        req_dst_trunk_member,
    output logic [2:0]  req_dst_trunk,
    output logic [9:0]  req_vlan_mask,
    output logic [3:0]  entry_flags,
    // Link state
    output logic [9:0]  link_up
);
    initial begin
        {req_valid, req_mcast, req_dst_trunk_member} = 3'h0;
        {req_src_port, req_dst_port, req_dst_trunk, entry_flags} = 15'h0;
        {req_sa, req_da, req_vlan_mask} = 106'h0;
        link_up = 10'h3FF;
    end
    // Destination 4'hF means a trunk-0 entry
    task automatic send(input logic mc, input logic [3:0] s, input logic [47:0] a, b,
                        input logic [3:0] d, input logic [9:0] v, input logic [3:0] f);
        @(posedge clk);
        req_valid            <= 1'b1;
        req_mcast            <= mc;
        req_src_port         <= s;
        {req_sa, req_da}     <= {a, b};
        req_dst_port         <= d;
        req_dst_trunk_member <= d == 4'hF;
        req_dst_trunk        <= 3'h0;
        req_vlan_mask        <= v;
        entry_flags          <= f;
        @(posedge clk);
        req_valid            <= 1'b0;
        // Address, source, VLAN and flag fields scrambled; mcast and destination fields left stale
        {req_sa, req_da}     <= ~{a, b};
        req_src_port         <= ~s;
        req_vlan_mask        <= ~v;
        entry_flags          <= ~f;
    endtask : send
    task automatic set_link(input logic [9:0] l);
        @(posedge clk);
        link_up <= l;
    endtask : set_link
endmodule : tmps_lookup_model

// ===== tb_trunk_and_mirror_port_select.sv
`timescale 1ns/1ps
module tb_trunk_and_mirror_port_select;
    localparam logic [11:0] CT  = tmps_pkg::OFS_CTRL;
    localparam logic [11:0] MN  = tmps_pkg::OFS_MON;
    localparam logic [47:0] SA0 = 48'h0123456789AB;
    localparam logic [47:0] DA0 = 48'hFEDCBA987654;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, rv, rmc, rdis, req_valid, req_mcast, req_dst_trunk_member;
    logic [3:0]  req_src_port, req_dst_port, flg;
    logic [47:0] req_sa, req_da;
    logic [2:0]  req_dst_trunk;
    logic [9:0]  req_vlan_mask, link_up, rfwd, rmir;
    int          miscompares = 0;
    int          num_checks = 0;
    always #12.5 clk = ~clk;
    tmps_lookup_model lk (.clk(clk), .req_valid(req_valid), .req_mcast(req_mcast),
        .req_src_port(req_src_port), .req_sa(req_sa), .req_da(req_da),
        .req_dst_port(req_dst_port), .req_dst_trunk_member(req_dst_trunk_member),
        .req_dst_trunk(req_dst_trunk), .req_vlan_mask(req_vlan_mask),
        .entry_flags(flg), .link_up(link_up));
    tmps_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .req_valid(req_valid),
        .req_mcast(req_mcast), .req_src_port(req_src_port), .req_sa(req_sa),
        .req_da(req_da), .req_dst_port(req_dst_port), .req_dst_trunk(req_dst_trunk),
        .req_dst_trunk_member(req_dst_trunk_member), .req_vlan_mask(req_vlan_mask),
        .sa_entry_mirror(flg[3]), .sa_entry_match_dst(flg[2]), .da_entry_mirror(flg[1]),
        .da_entry_match_dst(flg[0]), .link_up(link_up), .res_valid(rv), .res_mcast(rmc),
        .res_discard(rdis), .res_fwd(rfwd), .res_mirror(rmir));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy(output logic [31:0] q);
        logic ok;
        ok = 1'b0;
        for (int n = 0; n < 16 && ok !== 1'b1; n++) begin
            @(negedge clk);
            ok = hreadyout;
            q = hrdata;
            @(posedge clk);
        end
        if (ok !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        wait_rdy(q);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy(q);
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
        chk(32'(hresp), 32'h0);
    endtask : rd
    function automatic logic [2:0] fold(input logic [47:0] x);
        fold = 3'h0;
        for (int i = 0; i < 48; i += 3) begin
            fold ^= x[i +: 3];
        end
    endfunction : fold
    task automatic look(input logic mc, input logic [3:0] s, input logic [47:0] a, b,
                        input logic [3:0] d, input logic [9:0] v, input logic [3:0] f,
                        input logic [9:0] ef, em, input logic ed);
        lk.send(mc, s, a, b, d, v, f);
        #1;
        chk(32'(rv), 32'h1);
        chk(32'(rmc), 32'(mc));
        chk(32'(rfwd), 32'(ef));
        chk(32'(rmir), 32'(em));
        chk(32'(rdis), 32'(ed));
    endtask : look
    task automatic t_regs;
        rd(CT, 32'h0);
        rd(tmps_pkg::OFS_TMEM, 32'h0);
        wr(12'h200, 32'hFFFFFFFF);
        rd(12'h200, 32'h0);
        wr(tmps_pkg::OFS_TMEM, 32'h007);
        wr(tmps_pkg::OFS_TMEM + 12'h4, 32'h018);
        for (int i = 0; i < 8; i++) begin
            wr(tmps_pkg::OFS_TSEL + 12'(4 * i), 32'(i % 3));
            wr(tmps_pkg::OFS_TSEL + 12'(32 + 4 * i), 32'(3 + i % 2));
        end
        rd(tmps_pkg::OFS_TMEM + 12'h4, 32'h018);
        rd(tmps_pkg::OFS_LINK, 32'h3FF);
        $display("test regs done");
    endtask : t_regs
    task automatic t_hash;
        logic [47:0] a, b;
        logic [2:0]  k;
        for (int m = 0; m < 5; m++) begin
            a = SA0 + 48'(m * 7);
            b = DA0 - 48'(m * 5);
            k = m % 4 == 0 ? fold(a ^ b) : m == 1 ? fold(a) : m == 2 ? fold(b) : 3'h6;
            wr(CT, m == 3 ? 32'h7 : m == 4 ? 32'h3 : 32'(m));
            look(1'b0, 4'h6, a, b, 4'hF, 10'h0, 4'h0, 10'h1 << (k % 3), 10'h0, 1'b0);
        end
        wr(CT, 32'h0);
        $display("test hash done");
    endtask : t_hash
    task automatic t_disc;
        look(1'b0, 4'h1, SA0, DA0, 4'hF, 10'h0, 4'h0, 10'h0, 10'h0, 1'b1);
        rd(tmps_pkg::OFS_STAT, 32'h1);
        look(1'b0, 4'h6, SA0, DA0, 4'h8, 10'h0, 4'h0, 10'h100, 10'h0, 1'b0);
        $display("test discard done");
    endtask : t_disc
    task automatic t_fail;
        int k;
        k = fold(SA0 ^ DA0) % 3;
        lk.set_link(10'h3FF & ~(10'h1 << k));
        look(1'b0, 4'h6, SA0, DA0, 4'hF, 10'h0, 4'h0, k == 0 ? 10'h2 : 10'h1, 10'h0, 1'b0);
        lk.set_link(10'h3FF);
        $display("test failover done");
    endtask : t_fail
    task automatic t_mcast;
        logic [9:0] e;
        e = 10'h060 | (10'h1 << (fold(SA0 ^ DA0) % 3));
        look(1'b1, 4'h3, SA0, DA0, 4'h0, 10'h07F, 4'h0, e, 10'h0, 1'b0);
        wr(CT, 32'h1);
        e = 10'h060 | (10'h1 << (fold(SA0) % 3));
        look(1'b1, 4'h3, SA0, DA0, 4'h0, 10'h07F, 4'h0, e, 10'h0, 1'b0);
        wr(CT, 32'h0);
        $display("test multicast done");
    endtask : t_mcast
    task automatic t_mirror;
        logic [3:0] fl [4] = '{4'h8, 4'h3, 4'h2, 4'hC};
        logic [9:0] ex [4] = '{10'h080, 10'h080, 10'h000, 10'h000};
        wr(MN, 32'h75);
        wr(CT, 32'h20);
        look(1'b1, 4'h8, SA0, DA0, 4'h0, 10'h0E0, 4'h0, 10'h060, 10'h0, 1'b0);
        look(1'b0, 4'h5, SA0, DA0, 4'h8, 10'h0, 4'h0, 10'h100, 10'h080, 1'b0);
        for (int i = 0; i < 4; i++) begin
            look(1'b0, 4'h8, SA0, DA0, 4'h6, 10'h0, fl[i], 10'h040, ex[i], 1'b0);
        end
        wr(MN, 32'h4675);
        wr(CT, 32'h1A0);
        look(1'b0, 4'h5, SA0, DA0, 4'h6, 10'h0, 4'h0, 10'h040, 10'h090, 1'b0);
        $display("test mirror done");
    endtask : t_mirror
    task automatic t_flow;
        logic [47:0] fs, fd;
        fs = 48'h003311112222;
        fd = 48'h006644445555;
        wr(tmps_pkg::OFS_FSA_LO, 32'h11112222);
        wr(tmps_pkg::OFS_FSA_HI, 32'h33);
        wr(tmps_pkg::OFS_FDA_LO, 32'h44445555);
        wr(tmps_pkg::OFS_FDA_HI, 32'h66);
        rd(tmps_pkg::OFS_FSA_HI, 32'h33);
        wr(MN, 32'h75);
        for (int c = 0; c < 3; c++) begin
            wr(CT, c == 0 ? 32'h20 : c == 1 ? 32'h28 : 32'h38);
            look(1'b0, 4'h8, fs, fd, 4'h6, 10'h0, 4'h0, 10'h040, c == 0 ? 10'h0 : 10'h080, 1'b0);
            look(1'b0, 4'h8, fd, fs, 4'h6, 10'h0, 4'h0, 10'h040, c == 2 ? 10'h080 : 10'h0, 1'b0);
        end
        $display("test flow done");
    endtask : t_flow
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_hash();
        t_disc();
        t_fail();
        t_mcast();
        t_mirror();
        t_flow();
        give_verdict();
    end
endmodule : tb_trunk_and_mirror_port_select
